//--- rtl/atte_engine.sv
// Purpose: acquisition start/reference/pause trigger and sample/convert timing
// Assumes: timebases arrive as async levels; ticks taken on their rising edges
// Notes: all sources pass two flops before edge or level detection
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module atte_engine
  import atte_pkg::*;
#(
  parameter int NSRC = 15,
  parameter int CW = 16
) (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timebases and trigger sources (async)
  input wire logic sample_clk_timebase,
  input wire logic fast_timebase,
  input wire logic [NSRC-1:0] trig_src,
  input wire logic analog_cmp_event,
  // acquisition outputs
  output logic sample_clk,
  output logic conv_clk,
  output logic hold_done_pulse,
  output logic [15:0] prog_func_terminal,
  output logic acq_running,
  output logic acq_overrun
);
  initial begin
    if (NSRC < 1 || NSRC > 15) $error("NSRC must be 1..15");
    if (CW < 8 || CW > 32) $error("CW must be 8..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  localparam int NS = NSRC + 3;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [NS-1:0] sync3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {fast_timebase, sample_clk_timebase, analog_cmp_event, trig_src};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic [15:0] lvl;
  logic [15:0] lvl_d;
  assign lvl = 16'(sync2[NSRC:0]);
  assign lvl_d = 16'(sync3[NSRC:0]);
  logic stb_tick;
  logic ftb_tick;
  assign stb_tick = sync2[NSRC+1] & ~sync3[NSRC+1];
  assign ftb_tick = sync2[NSRC+2] & ~sync3[NSRC+2];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl;
  logic [31:0] trig;
  logic [31:0] sdiv;
  logic [31:0] cdiv;
  logic [31:0] dly;
  logic [31:0] bufsz;
  logic [31:0] pre;
  logic [31:0] wptr;
  atte_stat_s stat;
  // one driver per status bit; the packed word is only assembled for reads
  logic st_running;
  logic st_ref_seen;
  logic st_pre_done;
  logic st_overrun;
  logic st_paused;
  assign stat = {st_running, st_ref_seen, st_pre_done, st_overrun, st_paused};
  logic ph_wr;
  logic [7:0] ph_addr;
  logic sw_start;
  logic sw_stop;
  logic sw_clr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_wr <= hsel & htrans[1] & hwrite;
      ph_addr <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      trig <= 32'h0000_0000;
      sdiv <= SDIV_RESET;
      cdiv <= CDIV_RESET;
      dly <= DLY_RESET;
      bufsz <= BUF_RESET;
      pre <= PRE_RESET;
    end else if (ph_wr) begin
      case (ph_addr)
        ADDR_CTRL: ctrl <= hwdata;
        ADDR_TRIG: trig <= hwdata;
        ADDR_SDIV: sdiv <= hwdata;
        ADDR_CDIV: cdiv <= hwdata;
        ADDR_DLY: dly <= hwdata;
        ADDR_BUF: bufsz <= hwdata;
        ADDR_PRE: pre <= hwdata;
        default: ;
      endcase
    end
  end
  assign sw_start = ph_wr && ph_addr == ADDR_CMD && hwdata[CMD_START];
  assign sw_stop = ph_wr && ph_addr == ADDR_CMD && hwdata[CMD_STOP];
  assign sw_clr = ph_wr && ph_addr == ADDR_CMD && hwdata[CMD_CLR_OVR];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL: hrdata <= ctrl;
        ADDR_TRIG: hrdata <= trig;
        ADDR_SDIV: hrdata <= sdiv;
        ADDR_CDIV: hrdata <= cdiv;
        ADDR_DLY: hrdata <= dly;
        ADDR_BUF: hrdata <= bufsz;
        ADDR_PRE: hrdata <= pre;
        ADDR_STAT: hrdata <= {27'h0, stat};
        ADDR_WPTR: hrdata <= wptr;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger detection
  logic [3:0] s_src;
  logic [3:0] r_src;
  logic [3:0] p_src;
  assign s_src = trig[TRIG_START_SRC +: 4];
  assign r_src = trig[TRIG_REF_SRC +: 4];
  assign p_src = trig[TRIG_PAUSE_SRC +: 4];
  // analog comparison sits at index NSRC; SRC_ANALOG maps there
  logic [3:0] s_idx;
  logic [3:0] r_idx;
  logic [3:0] p_idx;
  assign s_idx = (s_src == SRC_ANALOG) ? 4'(NSRC) : s_src;
  assign r_idx = (r_src == SRC_ANALOG) ? 4'(NSRC) : r_src;
  assign p_idx = (p_src == SRC_ANALOG) ? 4'(NSRC) : p_src;
  logic start_edge;
  logic ref_edge;
  logic pause_act;
  // analog sources are always rising edge, regardless of the edge bit
  assign start_edge = (s_src != SRC_ANALOG && trig[TRIG_START_FALL]) ?
    (~lvl[s_idx] & lvl_d[s_idx]) : (lvl[s_idx] & ~lvl_d[s_idx]);
  assign ref_edge = (r_src != SRC_ANALOG && trig[TRIG_REF_FALL]) ?
    (~lvl[r_idx] & lvl_d[r_idx]) : (lvl[r_idx] & ~lvl_d[r_idx]);
  // level compare only; no edge term enters the pause
  assign pause_act = ctrl[CTRL_PAUSE_EN] && (lvl[p_idx] == ctrl[CTRL_PAUSE_HI]);

  ////////////////////////////////////////////////////////////////////////////
  // acquisition state machine
  atte_state_e state;
  logic [CW-1:0] cnt_dly;
  logic [CW-1:0] sdiv_cnt;
  logic [CW-1:0] smp_cnt;
  logic [CW-1:0] post_left;
  logic [CW-1:0] post_cnt;
  logic [7:0] conv_left;
  logic [CW-1:0] cdiv_cnt;
  logic conv_dly_phase;
  logic conv_tick;
  logic smp_fire;
  logic conv_fire;
  logic trig_go;
  logic stop_now;
  assign conv_tick = ctrl[CTRL_CONV_TB] ? ftb_tick : stb_tick;
  assign post_cnt = CW'(bufsz - pre);
  assign trig_go = ctrl[CTRL_START_EN] ? start_edge : sw_start;
  assign smp_fire = state == ATTE_RUN && stb_tick && sdiv_cnt == '0 && !pause_act;
  assign stop_now = sw_stop ||
    (!ctrl[CTRL_CONT] && smp_fire && (st_ref_seen ? post_left == CW'(1) :
     (!ctrl[CTRL_REF_EN] && smp_cnt == CW'(bufsz) - CW'(1))));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ATTE_IDLE;
      cnt_dly <= '0;
      sdiv_cnt <= '0;
      smp_cnt <= '0;
    end else begin
      case (state)
        ATTE_IDLE: if (sw_start) state <= ATTE_ARM;
        ATTE_ARM: if (sw_stop) state <= ATTE_DONE;
        else if (trig_go) begin
          state <= ATTE_DELAY;
          cnt_dly <= CW'(dly[15:0]);
          smp_cnt <= '0;
        end
        ATTE_DELAY: if (sw_stop) state <= ATTE_DONE;
        else if (stb_tick) begin
          if (cnt_dly <= CW'(1)) begin
            state <= ATTE_RUN;
            sdiv_cnt <= '0;
          end else cnt_dly <= cnt_dly - CW'(1);
        end
        ATTE_RUN: begin
          if (stop_now) state <= (ctrl[CTRL_RETRIG] && !sw_stop) ? ATTE_ARM : ATTE_DONE;
          else if (stb_tick && !pause_act) begin
            sdiv_cnt <= (sdiv_cnt == '0) ? CW'(sdiv) : sdiv_cnt - CW'(1);
            if (smp_fire) smp_cnt <= smp_cnt + CW'(1);
          end
        end
        ATTE_DONE: if (sw_start) state <= ATTE_ARM;
        default: state <= ATTE_IDLE;
      endcase
    end
  end

  // reference trigger and circular write pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ref_seen <= 1'b0;
      st_pre_done <= 1'b0;
      post_left <= '0;
      wptr <= 32'h0000_0000;
    end else if (state == ATTE_ARM && trig_go && !st_ref_seen) begin
      st_pre_done <= 1'b0;
      wptr <= 32'h0000_0000;
    end else if (state == ATTE_IDLE || state == ATTE_DONE) begin
      if (sw_start) begin
        st_ref_seen <= 1'b0;
        st_pre_done <= 1'b0;
        wptr <= 32'h0000_0000;
      end
    end else if (state == ATTE_RUN) begin
      if (smp_fire) begin
        wptr <= (wptr + 32'h1 >= bufsz) ? 32'h0 : wptr + 32'h1;
        if (smp_cnt + CW'(1) >= CW'(pre)) st_pre_done <= 1'b1;
        if (st_ref_seen) post_left <= post_left - CW'(1);
      end
      // ignore until pretrigger done; never rearm once seen
      if (ctrl[CTRL_REF_EN] && st_pre_done && !st_ref_seen && ref_edge) begin
        st_ref_seen <= 1'b1;
        post_left <= post_cnt;
      end
    end
  end

  // convert clock generation and overrun
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_left <= 8'h00;
      cdiv_cnt <= '0;
      conv_dly_phase <= 1'b0;
      st_overrun <= 1'b0;
    end else begin
      if (smp_fire) begin
        if (conv_left != 8'h00) st_overrun <= 1'b1;
        conv_left <= ctrl[CTRL_NCONV_LSB +: 8];
        cdiv_cnt <= CW'(dly[31:16]);
        conv_dly_phase <= 1'b1;
      end else if (conv_left != 8'h00 && conv_tick) begin
        if (cdiv_cnt <= CW'(1)) begin
          conv_left <= conv_left - 8'h01;
          cdiv_cnt <= CW'(cdiv);
          conv_dly_phase <= 1'b0;
        end else cdiv_cnt <= cdiv_cnt - CW'(1);
      end
      if (sw_clr && !(smp_fire && conv_left != 8'h00)) st_overrun <= 1'b0;
    end
  end
  assign conv_fire = conv_left != 8'h00 && !smp_fire && conv_tick && cdiv_cnt <= CW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the convert timebase itself is never routed out
  logic [15:0] next_pft;
  always_comb begin
    next_pft = 16'h0000;
    if (trig[TRIG_OUT_EN] && state == ATTE_ARM && trig_go)
      next_pft[trig[TRIG_START_OUT +: 4]] = 1'b1;
    if (trig[TRIG_HOLD_EN] && (conv_fire ^ ctrl[CTRL_HOLD_POL]))
      next_pft[trig[TRIG_HOLD_OUT +: 4]] = 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_clk <= 1'b0;
      conv_clk <= 1'b0;
      hold_done_pulse <= 1'b0;
      prog_func_terminal <= 16'h0000;
      acq_running <= 1'b0;
      acq_overrun <= 1'b0;
      st_running <= 1'b0;
      st_paused <= 1'b0;
    end else begin
      sample_clk <= smp_fire;
      conv_clk <= conv_fire;
      hold_done_pulse <= conv_fire ^ ctrl[CTRL_HOLD_POL];
      prog_func_terminal <= next_pft;
      acq_running <= state == ATTE_RUN || state == ATTE_DELAY;
      acq_overrun <= st_overrun;
      st_running <= state == ATTE_RUN || state == ATTE_DELAY;
      st_paused <= pause_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_no_sample_unstarted;
    @(posedge hclk) disable iff (!hresetn) (state != ATTE_RUN) |-> !smp_fire;
  endproperty
  a_no_sample_unstarted: assert property (p_no_sample_unstarted) else $error("sample outside run");
  property p_pause_holds;
    @(posedge hclk) disable iff (!hresetn) pause_act |=> !sample_clk;
  endproperty
  a_pause_holds: assert property (p_pause_holds) else $error("sample during pause");
  property p_overrun;
    @(posedge hclk) disable iff (!hresetn) (smp_fire && conv_left != 8'h00) |=> st_overrun ##1 acq_overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_ref_once;
    @(posedge hclk) disable iff (!hresetn) (st_ref_seen && state == ATTE_RUN) |=> $stable(st_ref_seen) || state != ATTE_RUN;
  endproperty
  a_ref_once: assert property (p_ref_once) else $error("reference rearmed");
  property p_ref_gate;
    @(posedge hclk) disable iff (!hresetn) ($rose(st_ref_seen)) |-> $past(st_pre_done);
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("reference before pretrigger");
  property p_hold_follows;
    @(posedge hclk) disable iff (!hresetn) conv_fire |=> (hold_done_pulse != ctrl[CTRL_HOLD_POL]) && conv_clk;
  endproperty
  a_hold_follows: assert property (p_hold_follows) else $error("hold pulse wrong");
  property p_delay_first;
    @(posedge hclk) disable iff (!hresetn) (state == ATTE_ARM && trig_go) |=> state == ATTE_DELAY;
  endproperty
  a_delay_first: assert property (p_delay_first) else $error("no start delay");
  property p_ignore_start;
    @(posedge hclk) disable iff (!hresetn) (state == ATTE_RUN && !stop_now) |=> state == ATTE_RUN;
  endproperty
  a_ignore_start: assert property (p_ignore_start) else $error("run broken");
  c_run: cover property (@(posedge hclk) state == ATTE_RUN ##1 sample_clk);
  c_ref: cover property (@(posedge hclk) $rose(st_ref_seen));
  c_retrig: cover property (@(posedge hclk) state == ATTE_RUN ##1 state == ATTE_ARM);
endmodule : atte_engine
`default_nettype wire

//--- rtl/atte_pkg.sv
// Purpose: constants and types for the acquisition trigger and timing engine
// Assumes: one clock hclk at 10 MHz, AHB-Lite register access
// Notes: timebase ticks are qualified by enables, not separate clocks
//
// What this block does
// - convert timebase from sample timebase or fast
// - convert timebase never leaves on a terminal
// - hold-done pulse after each conversion, routable
// - hold-done polarity selectable by software
// - start on trigger, or software command
// - stop on count, reference trigger, or software
// - retrigger replays full clock set per trigger; not with reference on, as st_ref_seen is never cleared on rearm
// - start triggers ignored while generating clocks
// - one reference trigger per acquisition only
// - digital start: source select plus edge
// - analog start: first rising comparison edge
// - start trigger routed out active-high pulse
// - posttrigger count is buffer minus pretrigger
// - reference ignored until pretrigger samples captured
// - full buffer overwrites oldest sample circularly
// - after reference, store posttrigger samples then stop
// - digital reference: source select plus edge
// - analog reference: first rising comparison edge
// - pause holds off internal sample clock
// - pause active level programmable high or low
// - analog pause on comparison level, either sense
// - pause acts on level only, never edges
// - start-to-first-sample delay, default four ticks
// - sample-to-first-convert delay, default three ticks
// - clocks ignored until valid start trigger
// - overrun if sample arrives before conversions done
package atte_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_SDIV = 8'h08;
  localparam logic [7:0] ADDR_CDIV = 8'h0c;
  localparam logic [7:0] ADDR_DLY = 8'h10;
  localparam logic [7:0] ADDR_BUF = 8'h14;
  localparam logic [7:0] ADDR_PRE = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  localparam logic [7:0] ADDR_WPTR = 8'h20;
  localparam logic [7:0] ADDR_CMD = 8'h24;
  // ctrl field positions
  localparam int CTRL_CONT = 0;
  localparam int CTRL_REF_EN = 1;
  localparam int CTRL_RETRIG = 2;
  localparam int CTRL_START_EN = 3;
  localparam int CTRL_CONV_TB = 4;
  localparam int CTRL_HOLD_POL = 5;
  localparam int CTRL_PAUSE_EN = 6;
  localparam int CTRL_PAUSE_HI = 7;
  localparam int CTRL_NCONV_LSB = 8;
  // trig field positions: 4-bit source, edge bit
  localparam int TRIG_START_SRC = 0;
  localparam int TRIG_START_FALL = 4;
  localparam int TRIG_REF_SRC = 8;
  localparam int TRIG_REF_FALL = 12;
  localparam int TRIG_PAUSE_SRC = 16;
  localparam int TRIG_START_OUT = 20;
  localparam int TRIG_HOLD_OUT = 24;
  localparam int TRIG_OUT_EN = 28;
  localparam int TRIG_HOLD_EN = 29;
  localparam logic [3:0] SRC_ANALOG = 4'hf;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0108;
  localparam logic [31:0] DLY_RESET = 32'h0003_0004;
  localparam logic [31:0] SDIV_RESET = 32'h0000_0009;
  localparam logic [31:0] CDIV_RESET = 32'h0000_0001;
  localparam logic [31:0] BUF_RESET = 32'h0000_0010;
  localparam logic [31:0] PRE_RESET = 32'h0000_0004;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_CLR_OVR = 2;
  localparam int FAST_TB_MHZ = 100;
  typedef enum logic [2:0] {ATTE_IDLE, ATTE_ARM, ATTE_DELAY, ATTE_RUN, ATTE_DONE} atte_state_e;
  typedef struct packed {
    logic running;
    logic ref_seen;
    logic pre_done;
    logic overrun;
    logic paused;
  } atte_stat_s;
endpackage : atte_pkg

//--- tb/atte_src_model.sv
// Purpose: far-side model: free-running timebases and trigger source levels
// Assumes: every source is a plain level, asynchronous to hclk
// Notes: fast timebase runs well below its real rate, since hclk could not sample it
`timescale 1ns/1ps
`default_nettype none
module atte_src_model #(
  parameter int NSRC = 15,
  parameter int TB_HALF = 185,
  parameter int FAST_HALF = 155,
  parameter int PULSE_NS = 600
) (
  // timebases
  output logic sample_clk_timebase,
  output logic fast_timebase,
  // trigger sources
  output logic [NSRC-1:0] trig_src,
  output logic analog_cmp_event
);
  initial begin
    sample_clk_timebase = 1'b0;
    fast_timebase = 1'b0;
    trig_src = '0;
    analog_cmp_event = 1'b0;
  end
  initial forever #(TB_HALF) sample_clk_timebase = ~sample_clk_timebase;
  initial forever #(FAST_HALF) fast_timebase = ~fast_timebase;
  //////////////////////////////////////////////////////////////////////////////
  // source code 15 is the comparison event, others index the digital sources
  task automatic set(input int idx, input logic v);
    if (idx == 15) analog_cmp_event = v;
    else trig_src[idx] = v;
  endtask : set
  // pulse wide enough to pass the two-flop synchroniser
  task automatic pulse(input int idx, input logic lvl);
    set(idx, lvl);
    #(PULSE_NS);
    set(idx, ~lvl);
  endtask : pulse
endmodule : atte_src_model
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the trigger and timing engine
// Assumes: hreadyout feeds hready; sample counts taken from output pulses
// Notes: counters never clear; every count check after samples before start uses differences of snapshots
`timescale 1ns/1ps
`default_nettype none
module tb;
  import atte_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hpol, pf_q;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic stb, ftb, acmp, sample_clk, conv_clk, hold_done_pulse, acq_running, acq_overrun;
  logic [14:0] trig_src;
  logic [15:0] prog_func_terminal;
  int bad_count, cmp_count, cyc, ns, nc, nh, np, s0, c0, h0, p0, mark;
  logic [7:0] ra[6] = '{ADDR_CTRL, ADDR_SDIV, ADDR_CDIV, ADDR_DLY, ADDR_BUF, ADDR_PRE};
  logic [31:0] rv[6] = '{CTRL_RESET, SDIV_RESET, CDIV_RESET, DLY_RESET, BUF_RESET, PRE_RESET};
  atte_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_clk_timebase(stb), .fast_timebase(ftb),
    .trig_src(trig_src), .analog_cmp_event(acmp), .sample_clk(sample_clk), .conv_clk(conv_clk),
    .hold_done_pulse(hold_done_pulse), .prog_func_terminal(prog_func_terminal),
    .acq_running(acq_running), .acq_overrun(acq_overrun));
  atte_src_model src (.sample_clk_timebase(stb), .fast_timebase(ftb), .trig_src(trig_src),
    .analog_cmp_event(acmp));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (sample_clk === 1'b1) ns <= ns + 1;
    if (conv_clk === 1'b1) nc <= nc + 1;
    if ((hold_done_pulse ^ hpol) === 1'b1) nh <= nh + 1;
    if (prog_func_terminal[5] === 1'b1 && pf_q !== 1'b1) np <= np + 1;
    pf_q <= prog_func_terminal[5];
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one single-word transfer; hready is waited for, never assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_run(input logic v);
    for (int i = 0; i < 4000 && acq_running !== v; i++) @(posedge hclk);
  endtask : wait_run
  task automatic wait_n(input int n, input int base);
    for (int i = 0; i < 4000 && ns - base < n; i++) @(posedge hclk);
  endtask : wait_n
  task automatic snap;
    s0 = ns;
    c0 = nc;
    h0 = nh;
    p0 = np;
  endtask : snap
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, hpol, pf_q} = '0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {bad_count, cmp_count, cyc, ns, nc, nh, np} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", rdv, rv[i]);
    end
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    chk("unmapped", rdv, 32'h0);
    chk("okay response", 32'(hresp), 32'h0);
    chk("samples before start", 32'(ns), 32'h0);
    $display("test registers done");
    wr(ADDR_BUF, 32'h4);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL, 32'h0200 | 32'(p) << 5 | 32'(p) << 4);
      hpol = p[0];
      repeat (5) @(posedge hclk);
      chk("hold idle", 32'(hold_done_pulse), 32'(p));
      snap();
      wr(ADDR_CMD, 32'h1);
      wr(ADDR_CMD, 32'h1);
      wait_run(1'b1);
      wait_run(1'b0);
      // the last sample's conversions finish after the run flag drops
      repeat (40) @(posedge hclk);
      chk("sw samples", 32'(ns - s0), 32'h4);
      chk("conversions", 32'(nc - c0), 32'h8);
      chk("hold pulses", 32'(nh - h0), 32'h8);
      chk("no overrun", 32'(acq_overrun), 32'h0);
    end
    hpol = 1'b0;
    $display("test software start done");
    for (int f = 0; f < 3; f++) begin
      src.set(f == 2 ? 15 : 2, f == 1);
      wr(ADDR_TRIG, f == 2 ? 32'h1050_000f : 32'h1050_0002 | 32'(f) << 4);
      wr(ADDR_CTRL, 32'h0208);
      snap();
      wr(ADDR_CMD, 32'h1);
      repeat (30) @(posedge hclk);
      chk("armed idle", 32'(acq_running), 32'h0);
      src.pulse(f == 2 ? 15 : 2, f != 1);
      wait_run(1'b1);
      wait_run(1'b0);
      chk("hw samples", 32'(ns - s0), 32'h4);
      chk("start out", 32'(np - p0), 32'h1);
    end
    $display("test hardware start done");
    src.set(2, 1'b0);
    wr(ADDR_TRIG, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h020c);
    snap();
    wr(ADDR_CMD, 32'h1);
    src.pulse(2, 1'b1);
    wait_n(1, s0);
    src.pulse(2, 1'b1);
    wait_run(1'b0);
    chk("retrig first", 32'(ns - s0), 32'h4);
    src.pulse(2, 1'b1);
    wait_run(1'b1);
    wait_run(1'b0);
    chk("retrig second", 32'(ns - s0), 32'h8);
    wr(ADDR_CMD, 32'h2);
    $display("test retrigger done");
    wr(ADDR_BUF, 32'h8);
    wr(ADDR_PRE, 32'h3);
    wr(ADDR_TRIG, 32'h0000_0300);
    src.set(3, 1'b0);
    wr(ADDR_CTRL, 32'h0202);
    snap();
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h1);
    wait_run(1'b1);
    src.pulse(3, 1'b1);
    wait_n(10, s0);
    chk("circular run", 32'(acq_running), 32'h1);
    mark = ns;
    src.pulse(3, 1'b1);
    wait_n(2, mark);
    src.pulse(3, 1'b1);
    wait_run(1'b0);
    chk("post samples", 32'(ns - mark), 32'h5);
    $display("test reference done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TRIG, (i == 2 ? 32'hf : 32'h1) << 16);
      src.set(i == 2 ? 15 : 1, i == 1);
      wr(ADDR_CTRL, 32'h0141 | 32'(i != 1) << 7);
      wr(ADDR_CMD, 32'h1);
      wr(ADDR_CMD, 32'h1);
      wait_run(1'b1);
      repeat (100) @(posedge hclk);
      src.set(i == 2 ? 15 : 1, i != 1);
      repeat (10) @(posedge hclk);
      mark = ns;
      repeat (200) @(posedge hclk);
      chk("paused samples", 32'(ns - mark), 32'h0);
      rd(ADDR_STAT);
      chk("paused flag", 32'(rdv[0]), 32'h1);
      src.set(i == 2 ? 15 : 1, i == 1);
      repeat (200) @(posedge hclk);
      chk("resumed", 32'(ns - mark > 3), 32'h1);
      wr(ADDR_CMD, 32'h2);
      wait_run(1'b0);
      chk("sw stop", 32'(acq_running), 32'h0);
    end
    $display("test pause done");
    wr(ADDR_SDIV, 32'h1);
    wr(ADDR_CTRL, 32'h0401);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h1);
    for (int i = 0; i < 2000 && acq_overrun !== 1'b1; i++) @(posedge hclk);
    chk("overrun", 32'(acq_overrun), 32'h1);
    wr(ADDR_CMD, 32'h2);
    wait_run(1'b0);
    wr(ADDR_CMD, 32'h4);
    repeat (3) @(posedge hclk);
    chk("overrun clear", 32'(acq_overrun), 32'h0);
    $display("test overrun done");
    summarize();
  end
endmodule : tb
`default_nettype wire
